// ==== rtl/cgc_top.sv ====
// Clock gating control: gate registers, watchdog clock enable and
// fault on access to an unclocked unit, with an APB register slave.
// Assumes one clock, sys_clk, and that unit_req comes from sys_clk logic.
//
// Our own choice: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module cgc_top
#(
    parameter logic [31:0] BASE_ADDR     = cgc_pkg::CGC_BASE,
    parameter logic [3:0]  PORTS_PRESENT = cgc_pkg::CGC_PORTS_RST
)
(
    // Clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 resetn,
    // APB slave
    input  wire cgc_pkg::cgc_apb_req_t apb_req,
    output cgc_pkg::cgc_apb_rsp_t      apb_rsp,
    // Power state
    input  wire cgc_pkg::cgc_pwr_t     pwr_state,
    // Watchdog unit
    input  wire logic                 unit_req,
    output logic                      wd_clk_en,
    output logic                      unit_fault,
    // Interrupt
    output logic                      irq
);
    import cgc_pkg::*;

    logic [31:0]         run_q;
    logic [31:0]         sleep_q;
    logic [31:0]         deep_q;
    logic                acg_q;
    logic [CGC_EV_N-1:0] stat_q;
    logic [CGC_EV_N-1:0] mask_q;
    cgc_pwr_t            pwr_q;
    cgc_apb_rsp_t        rsp_q;
    logic                wd_en_q;
    logic                fault_q;
    logic                irq_q;
    logic                first_q;
    logic [31:0]         caps;
    logic [31:0]         rdata_d;
    logic                err_d;
    logic                sel_en;
    logic                acc;
    logic                commit;
    logic                wr;
    logic                in_page;
    logic [11:0]         off;
    logic [CGC_EV_N-1:0] ev;

    assign apb_rsp    = rsp_q;
    assign wd_clk_en  = wd_en_q;
    assign unit_fault = fault_q;
    assign irq        = irq_q;

    // Capability bits share positions with the per-port gate bits
    genvar g;
    generate
        for (g = 0; g < 32; g++)
        begin : g_caps
            if (g >= CGC_PORT_A_BIT && g <= CGC_PORT_D_BIT)
            begin : g_port
                assign caps[g] = PORTS_PRESENT[g - CGC_PORT_A_BIT];
            end
            else
            begin : g_zero
                assign caps[g] = 1'b0;
            end
        end
    endgenerate

    // Address decode relative to the base
    assign in_page = (apb_req.paddr & CGC_PAGE_MASK) == BASE_ADDR;
    assign off     = apb_req.paddr[11:0];
    assign acc     = apb_req.psel && apb_req.penable;
    // Register writes land only at the edge where pready is seen high
    assign commit  = acc && rsp_q.pready;
    assign wr      = commit && apb_req.pwrite && in_page;

    always_comb
    begin
        rdata_d = 32'h00000000;
        err_d   = 1'b0;
        if (!in_page || off[1:0] != 2'h0)
        begin
            err_d = 1'b1;
        end
        else
        begin
            unique case (off)
                CGC_OFF_CAPS:  rdata_d = caps;
                CGC_OFF_RUN:   rdata_d = run_q;
                CGC_OFF_SLEEP: rdata_d = sleep_q;
                CGC_OFF_DEEP:  rdata_d = deep_q;
                CGC_OFF_CFG:   rdata_d[CGC_ACG_BIT] = acg_q;
                CGC_OFF_STAT:  rdata_d[CGC_EV_N-1:0] = stat_q;
                CGC_OFF_MASK:  rdata_d[CGC_EV_N-1:0] = mask_q;
                default:       err_d = 1'b1;
            endcase
        end
    end

    // One wait state keeps every answer signal straight from a flop
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rsp_q <= '0;
        end
        else if (acc && !rsp_q.pready)
        begin
            rsp_q.pready  <= 1'b1;
            rsp_q.pslverr <= err_d;
            rsp_q.prdata  <= apb_req.pwrite ? 32'h00000000 : rdata_d;
        end
        else
        begin
            rsp_q <= '0;
        end
    end

    // Only the watchdog bit is writable; the rest stays zero
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            run_q   <= CGC_GATE_RST;
            sleep_q <= CGC_GATE_RST;
            deep_q  <= CGC_GATE_RST;
        end
        else if (wr)
        begin
            if (off == CGC_OFF_RUN)
            begin
                run_q[CGC_WD_BIT] <= apb_req.pwdata[CGC_WD_BIT];
            end
            if (off == CGC_OFF_SLEEP)
            begin
                sleep_q[CGC_WD_BIT] <= apb_req.pwdata[CGC_WD_BIT];
            end
            if (off == CGC_OFF_DEEP)
            begin
                deep_q[CGC_WD_BIT] <= apb_req.pwdata[CGC_WD_BIT];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            acg_q  <= CGC_ACG_RST;
            mask_q <= '0;
        end
        else if (wr)
        begin
            if (off == CGC_OFF_CFG)
            begin
                acg_q <= apb_req.pwdata[CGC_ACG_BIT];
            end
            if (off == CGC_OFF_MASK)
            begin
                mask_q <= apb_req.pwdata[CGC_EV_N-1:0];
            end
        end
    end

    cgc_gate_sel u_sel
    (
        .run_bit   (run_q[CGC_WD_BIT]),
        .sleep_bit (sleep_q[CGC_WD_BIT]),
        .deep_bit  (deep_q[CGC_WD_BIT]),
        .auto_clock_gating       (acg_q),
        .pwr       (pwr_state),
        .gate_en   (sel_en)
    );

    // Enable feeds a glitch-free clock gate cell outside this block
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            wd_en_q <= 1'b0;
        end
        else
        begin
            wd_en_q <= sel_en;
        end
    end

    // Fault is judged against the enable the unit really sees
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fault_q <= 1'b0;
        end
        else
        begin
            fault_q <= unit_req && !wd_en_q;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pwr_q <= CGC_PWR_RUN;
        end
        else
        begin
            pwr_q <= pwr_state;
        end
    end

    assign ev[CGC_EV_FAULT] = unit_req && !wd_en_q;
    assign ev[CGC_EV_PWR]   = pwr_state != pwr_q;

    // A new event wins over a write-one clear in the same cycle
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            stat_q <= '0;
        end
        else if (wr && off == CGC_OFF_STAT)
        begin
            stat_q <= (stat_q & ~apb_req.pwdata[CGC_EV_N-1:0]) | ev;
        end
        else
        begin
            stat_q <= stat_q | ev;
        end
    end

    // One cycle behind the status bits
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= |(stat_q & mask_q);
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            first_q <= 1'b1;
        end
        else
        begin
            first_q <= 1'b0;
        end
    end

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    sequence s_setup_rd(logic [11:0] a);
        apb_req.psel && !apb_req.penable && !apb_req.pwrite && in_page
            && off == a;
    endsequence

    sequence s_access;
        acc && !rsp_q.pready ##1 acc && rsp_q.pready;
    endsequence

    property p_run_on;
        pwr_state == CGC_PWR_RUN && run_q[CGC_WD_BIT] |=> wd_en_q;
    endproperty
    a_run_on: assert property (p_run_on)
        else $error("Watchdog clock off while run gate set");

    property p_off;
        !sel_en [*2] |-> !wd_en_q ##1 !wd_en_q;
    endproperty
    a_off: assert property (p_off)
        else $error("Watchdog clock on while its gate is clear");

    property p_fault;
        unit_req |=> fault_q == !$past(wd_en_q);
    endproperty
    a_fault: assert property (p_fault)
        else $error("Fault flag wrong for unit access");

    property p_fault_gated;
        unit_req && !wd_en_q |=> fault_q && stat_q[CGC_EV_FAULT];
    endproperty
    a_fault_gated: assert property (p_fault_gated)
        else $error("Access to unclocked unit did not fault");

    property p_reset;
        first_q |-> run_q == 32'h0 && sleep_q == 32'h0 && deep_q == 32'h0
            && !wd_en_q;
    endproperty
    a_reset: assert property (p_reset)
        else $error("Gate bits not zero after reset");

    property p_sleep;
        acg_q && pwr_state == CGC_PWR_SLEEP
            |=> wd_en_q == $past(sleep_q[CGC_WD_BIT]);
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("Sleep gate not applied during sleep");

    property p_deep;
        acg_q && pwr_state == CGC_PWR_DEEP
            |=> wd_en_q == $past(deep_q[CGC_WD_BIT]);
    endproperty
    a_deep: assert property (p_deep)
        else $error("Deep-sleep gate not applied during deep sleep");

    property p_no_acg;
        !acg_q |=> wd_en_q == $past(run_q[CGC_WD_BIT]);
    endproperty
    a_no_acg: assert property (p_no_acg)
        else $error("Run gate ignored without auto gating");

    property p_wr_run;
        wr && off == CGC_OFF_RUN
            |=> run_q[CGC_WD_BIT] == $past(apb_req.pwdata[CGC_WD_BIT]);
    endproperty
    a_wr_run: assert property (p_wr_run)
        else $error("Run watchdog gate did not take write");

    property p_rsvd;
        run_q[31:4] == 28'h0 && run_q[2:0] == 3'h0
            && sleep_q[31:4] == 28'h0 && sleep_q[2:0] == 3'h0
            && deep_q[31:4] == 28'h0 && deep_q[2:0] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd)
        else $error("Reserved gate bit not zero");

    property p_caps;
        s_setup_rd(CGC_OFF_CAPS) ##1 s_access
            |-> rsp_q.prdata == {28'h0, PORTS_PRESENT} && !rsp_q.pslverr;
    endproperty
    a_caps: assert property (p_caps)
        else $error("Capability read wrong");

    property p_irq;
        |(stat_q & mask_q) |=> irq_q;
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt not raised for unmasked status");

endmodule : cgc_top
`default_nettype wire

// ==== rtl/cgc_pkg.sv ====
// Constants, types and register map of the clock gating control block.
// Assumes an APB master on sys_clk and a power manager on the same clock.
package cgc_pkg;

    // Register byte offsets from the system control base
    localparam logic [11:0] CGC_OFF_CAPS  = 12'h01c;
    localparam logic [11:0] CGC_OFF_RUN   = 12'h100;
    localparam logic [11:0] CGC_OFF_SLEEP = 12'h110;
    localparam logic [11:0] CGC_OFF_DEEP  = 12'h120;
    localparam logic [11:0] CGC_OFF_CFG   = 12'h200;
    localparam logic [11:0] CGC_OFF_STAT  = 12'h204;
    localparam logic [11:0] CGC_OFF_MASK  = 12'h208;

    localparam logic [31:0] CGC_BASE      = 32'h400fe000;
    localparam logic [31:0] CGC_PAGE_MASK = 32'hfffff000;

    // Field positions
    localparam int CGC_WD_BIT     = 3;
    localparam int CGC_ACG_BIT    = 0;
    localparam int CGC_EV_FAULT   = 0;
    localparam int CGC_EV_PWR     = 1;
    localparam int CGC_PORT_A_BIT = 0;
    localparam int CGC_PORT_D_BIT = 3;
    localparam int CGC_EV_N       = 2;

    // Reset values
    localparam logic [31:0] CGC_GATE_RST  = 32'h00000000;
    localparam logic        CGC_ACG_RST   = 1'b0;
    localparam logic [3:0]  CGC_PORTS_RST = 4'hf;

    typedef enum logic [1:0] {
        CGC_PWR_RUN,
        CGC_PWR_SLEEP,
        CGC_PWR_DEEP
    } cgc_pwr_t;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] paddr;
        logic [31:0] pwdata;
    } cgc_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } cgc_apb_rsp_t;

endpackage : cgc_pkg

// ==== rtl/cgc_gate_sel.sv ====
// Picks the gate bit that governs a unit in the present power state.
// Assumes the power state and the gate bits are on sys_clk.
`timescale 1ns/100ps
`default_nettype none
module cgc_gate_sel
(
    // Gate bits
    input  wire logic             run_bit,
    input  wire logic             sleep_bit,
    input  wire logic             deep_bit,
    // Mode
    input  wire logic             auto_clock_gating,
    input  wire cgc_pkg::cgc_pwr_t pwr,
    // Result
    output logic                  gate_en
);
    import cgc_pkg::*;

    always_comb
    begin
        gate_en = run_bit;
        if (auto_clock_gating)
        begin
            unique case (pwr)
                CGC_PWR_RUN:   gate_en = run_bit;
                CGC_PWR_SLEEP: gate_en = sleep_bit;
                CGC_PWR_DEEP:  gate_en = deep_bit;
                default:       gate_en = run_bit;
            endcase
        end
    end

endmodule : cgc_gate_sel
`default_nettype wire

// ==== verif/cgc_top_test.sv ====
// Self-checking bench for the clock gating control block.
// Assumes the rtl/ package and modules are compiled before this file.
`timescale 1ns/100ps
`default_nettype none
module cgc_top_test;
    import cgc_pkg::*;

    logic         sys_clk;
    logic         resetn;
    cgc_apb_req_t req;
    cgc_apb_rsp_t rsp;
    cgc_pwr_t     pwr;
    logic         unit_req;
    logic         wd_clk_en;
    logic         unit_fault;
    logic         irq;
    int           error_cnt;
    int           compares;
    logic [31:0]  rd;
    logic         err;

    cgc_top uut
    (
        .sys_clk    (sys_clk),
        .resetn     (resetn),
        .apb_req    (req),
        .apb_rsp    (rsp),
        .pwr_state  (pwr),
        .unit_req   (unit_req),
        .wd_clk_en  (wd_clk_en),
        .unit_fault (unit_fault),
        .irq        (irq)
    );

    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic results;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : results

    task automatic chk(input string name, input logic [31:0] exp,
        input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    // Samples pready at the edge itself and waits up to 20 edges for a late answer
    task automatic apb(input logic wr, input logic [31:0] addr,
        input logic [31:0] wdata);
        int n;
        @(posedge sys_clk);
        req.psel    <= 1'b1;
        req.penable <= 1'b0;
        req.pwrite  <= wr;
        req.paddr   <= addr;
        req.pwdata  <= wdata;
        @(posedge sys_clk);
        req.penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge sys_clk);
            n++;
        end
        while (rsp.pready !== 1'b1 && n < 20);
        chk("pready", 32'h1, {31'h0, rsp.pready});
        // A slave that never answers ends the run here
        if (rsp.pready !== 1'b1)
            results();
        rd  = rsp.prdata;
        err = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [11:0] off, input logic [31:0] d);
        apb(1'b1, CGC_BASE + {20'h00000, off}, d);
    endtask : wr

    task automatic rdchk(input logic [11:0] off, input logic [31:0] exp,
        input string name);
        apb(1'b0, CGC_BASE + {20'h00000, off}, 32'h00000000);
        chk(name, exp, rd);
        chk("pslverr", 32'h0, {31'h0, err});
    endtask : rdchk

    task automatic test_reset;
        logic [11:0] offs [3];
        offs = '{CGC_OFF_RUN, CGC_OFF_SLEEP, CGC_OFF_DEEP};
        resetn <= 1'b0;
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        @(posedge sys_clk);
        chk("wd_clk_en", 32'h0, {31'h0, wd_clk_en});
        chk("irq", 32'h0, {31'h0, irq});
        foreach (offs[i])
            rdchk(offs[i], 32'h00000000, "gate reset");
        rdchk(CGC_OFF_CAPS, 32'h0000000f, "caps");
        $display("test_reset done");
    endtask : test_reset

    task automatic test_gate_rw;
        logic [11:0] offs [3];
        offs = '{CGC_OFF_RUN, CGC_OFF_SLEEP, CGC_OFF_DEEP};
        foreach (offs[i])
        begin
            wr(offs[i], 32'hffffffff);
            rdchk(offs[i], 32'h00000008, "gate bits");
        end
        wr(CGC_OFF_CAPS, 32'h00000000);
        chk("caps write err", 32'h0, {31'h0, err});
        rdchk(CGC_OFF_CAPS, 32'h0000000f, "caps ro");
        $display("test_gate_rw done");
    endtask : test_gate_rw

    // Bits are {deep, sleep, run}
    task automatic sel_case(input logic auto_clock_gating, input logic [2:0] bits);
        cgc_pwr_t s [3];
        logic     exp;
        s = '{CGC_PWR_RUN, CGC_PWR_SLEEP, CGC_PWR_DEEP};
        wr(CGC_OFF_CFG, {31'h0, auto_clock_gating});
        wr(CGC_OFF_RUN, {28'h0, bits[0], 3'h0});
        wr(CGC_OFF_SLEEP, {28'h0, bits[1], 3'h0});
        wr(CGC_OFF_DEEP, {28'h0, bits[2], 3'h0});
        foreach (s[i])
        begin
            pwr <= s[i];
            repeat (3) @(posedge sys_clk);
            exp = auto_clock_gating ? bits[i] : bits[0];
            chk("wd_clk_en", {31'h0, exp}, {31'h0, wd_clk_en});
        end
        pwr <= CGC_PWR_RUN;
    endtask : sel_case

    task automatic test_select;
        sel_case(1'b0, 3'b001);
        sel_case(1'b0, 3'b110);
        sel_case(1'b1, 3'b101);
        sel_case(1'b1, 3'b010);
        $display("test_select done");
    endtask : test_select

    // Waits first so the enable has followed the last register write
    task automatic unit_pulse(input logic exp);
        repeat (2) @(posedge sys_clk);
        unit_req <= 1'b1;
        @(posedge sys_clk);
        unit_req <= 1'b0;
        chk("fault early", 32'h0, {31'h0, unit_fault});
        @(posedge sys_clk);
        chk("unit_fault", {31'h0, exp}, {31'h0, unit_fault});
        @(posedge sys_clk);
        chk("fault pulse", 32'h0, {31'h0, unit_fault});
    endtask : unit_pulse

    task automatic test_fault;
        rdchk(CGC_OFF_STAT, 32'h00000002, "status power");
        wr(CGC_OFF_CFG, 32'h00000000);
        wr(CGC_OFF_RUN, 32'h00000000);
        wr(CGC_OFF_STAT, 32'h00000003);
        unit_pulse(1'b1);
        rdchk(CGC_OFF_STAT, 32'h00000001, "status fault");
        chk("irq masked", 32'h0, {31'h0, irq});
        wr(CGC_OFF_MASK, 32'h00000001);
        repeat (2) @(posedge sys_clk);
        chk("irq on", 32'h1, {31'h0, irq});
        wr(CGC_OFF_STAT, 32'h00000001);
        repeat (2) @(posedge sys_clk);
        chk("irq cleared", 32'h0, {31'h0, irq});
        wr(CGC_OFF_RUN, 32'h00000008);
        unit_pulse(1'b0);
        $display("test_fault done");
    endtask : test_fault

    task automatic test_decode;
        apb(1'b0, CGC_BASE + 32'h00000004, 32'h00000000);
        chk("unmapped err", 32'h1, {31'h0, err});
        apb(1'b0, CGC_BASE + 32'h00000101, 32'h00000000);
        chk("misaligned err", 32'h1, {31'h0, err});
        apb(1'b1, CGC_BASE + 32'h00001100, 32'h00000000);
        chk("off page err", 32'h1, {31'h0, err});
        rdchk(CGC_OFF_RUN, 32'h00000008, "run kept");
        $display("test_decode done");
    endtask : test_decode

    initial
    begin
        repeat (20000) @(posedge sys_clk);
        error_cnt++;
        results();
    end

    initial
    begin
        resetn    = 1'b0;
        req       = '0;
        pwr       = CGC_PWR_RUN;
        unit_req  = 1'b0;
        error_cnt = 0;
        compares  = 0;
        test_reset();
        test_gate_rw();
        test_reset();
        test_select();
        test_fault();
        test_decode();
        results();
    end
endmodule : cgc_top_test
`default_nettype wire
